// file: sim/sce_cmd_asserts.sv
// Checker of the command executor's port behaviour.
`timescale 1ns/1ps
module sce_cmd_asserts #(
  parameter int PULSE_CYC = sce_pkg::CLR_PULSE_CYC
) (
  input wire logic clk_sys, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic hsel, // Select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Transfer.
  input wire logic hwrite, // Write.
  input wire logic [31:0] hwdata, // Data.
  input wire logic hready, // Ready.
  input wire logic driveDisableOutput, // Disable pin.
  input wire logic clearPulseOutput, // Clear pin.
  input wire logic moveActive, // Moving.
  input wire logic [31:0] driveSpeed // Speed.
);
  logic cmdPhase_reg;
  logic [6:0] cmd_reg;
  int clrCnt_reg;
  // A rewrite of the stored code is no command, so it is filtered here.
  wire newCmd = cmdPhase_reg && hwdata[6:0] != cmd_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmdPhase_reg <= 1'b0;
      cmd_reg <= 7'h00;
      clrCnt_reg <= 0;
    end else begin
      cmdPhase_reg <= hsel && hready && htrans[1] && hwrite &&
        haddr[7:0] == sce_pkg::OFF_CMD;
      if (cmdPhase_reg) cmd_reg <= hwdata[6:0];
      clrCnt_reg <= clearPulseOutput ? clrCnt_reg + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_cmd(logic [6:0] c);
    newCmd && hwdata[6:0] == c;
  endsequence
  property p_dis_on;
    s_cmd(sce_pkg::CMD_DIS_ON) |-> ##[1:2] driveDisableOutput;
  endproperty
  property p_dis_off;
    s_cmd(sce_pkg::CMD_DIS_OFF) |-> ##[1:2] !driveDisableOutput;
  endproperty
  property p_clr_start;
    s_cmd(sce_pkg::CMD_CLR_PULSE) |-> ##[1:2] clearPulseOutput;
  endproperty
  property p_clr_cause;
    $rose(clearPulseOutput) |-> $past(newCmd) || $past(newCmd, 2);
  endproperty
  property p_clr_len;
    $fell(clearPulseOutput) |-> clrCnt_reg == PULSE_CYC;
  endproperty
  property p_inter_start;
    s_cmd(sce_pkg::CMD_INTER) |-> ##[1:3] moveActive;
  endproperty
  property p_stop_idle;
    s_cmd(sce_pkg::CMD_IDLE) |-> ##[1:3] !moveActive;
  endproperty
  property p_idle_speed;
    !moveActive && !$past(moveActive) |-> driveSpeed == 32'h0000_0000;
  endproperty
  a_dis_on: assert property (p_dis_on)
    else $error("disable output not raised");
  a_dis_off: assert property (p_dis_off)
    else $error("disable output not lowered");
  a_clr_start: assert property (p_clr_start)
    else $error("clear pulse not started");
  a_clr_cause: assert property (p_clr_cause)
    else $error("clear pulse without command");
  a_clr_len: assert property (p_clr_len)
    else $error("clear pulse length wrong");
  a_inter_start: assert property (p_inter_start)
    else $error("interactive move not started");
  a_stop_idle: assert property (p_stop_idle)
    else $error("move not stopped by idle code");
  a_idle_speed: assert property (p_idle_speed)
    else $error("speed nonzero while stopped");
endmodule
bind sce_stepper_command_executor sce_cmd_asserts #(
  .PULSE_CYC(PULSE_CYC)
) u_chk (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .driveDisableOutput, .clearPulseOutput, .moveActive,
  .driveSpeed);

// file: sim/sce_host.sv
// Controller model that reaches the block over AHB-Lite.
`timescale 1ns/1ps
module sce_host (
  input wire logic clk_sys, // Clock.
  input wire logic hready, // Ready.
  input wire logic [31:0] hrdata, // Read data.
  output logic hsel, // Select.
  output logic [31:0] haddr, // Address.
  output logic [1:0] htrans, // Transfer.
  output logic hwrite, // Write.
  output logic [2:0] hsize, // Size.
  output logic [31:0] hwdata // Data.
);
  logic timedOut = 1'b0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // A stuck slave raises timedOut instead of hanging the run.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) timedOut = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
endmodule

// file: sim/stepper_command_executor_tb.sv
// Self-checking bench of the stepper command executor.
`timescale 1ns/1ps
module stepper_command_executor_tb;
  localparam int PC = 20;
  localparam logic [31:0] SPD = 32'h0000_0300;
  localparam logic [31:0] S0 = 32'h0000_0100;
  localparam logic [31:0] S1 = 32'h0000_0200;
  typedef struct packed {
    logic [6:0] cmd;
    logic [3:0] mode;
    logic dis;
    logic act;
    logic dir;
  } sce_row_t;
  // Codes are literal so a wrong package encoding is caught too.
  localparam sce_row_t ROWS [8] = '{
    '{7'h76, 4'h0, 1'b1, 1'b0, 1'b0}, '{7'h77, 4'h0, 1'b0, 1'b0, 1'b0},
    '{7'h7A, 4'h2, 1'b0, 1'b1, 1'b0}, '{7'h7A, 4'h3, 1'b0, 1'b1, 1'b1},
    '{7'h7A, 4'h4, 1'b0, 1'b1, 1'b0}, '{7'h7A, 4'h5, 1'b0, 1'b1, 1'b1},
    '{7'h7B, 4'h8, 1'b0, 1'b1, 1'b0}, '{7'h7B, 4'h9, 1'b0, 1'b1, 1'b1}};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic sensorIn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, dis, clr, act, dir;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, driveSpeed, q;
  int num_errors = 0;
  int tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  sce_stepper_command_executor #(.PULSE_CYC(PC)) u_dut (.clk_sys, .arst_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .referencePointSensorInput(sensorIn),
    .driveDisableOutput(dis), .clearPulseOutput(clr), .moveActive(act),
    .moveDir(dir), .driveSpeed);
  sce_host u_host (.clk_sys, .hready(hreadyout), .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);
  task automatic finish_test;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bail(input logic ok);
    if (!ok) begin
      num_errors++;
      finish_test();
    end
  endtask
  always @(posedge u_host.timedOut) bail(1'b0);
  task automatic cmp1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(a, 1'b0, 32'h0000_0000, q);
  endtask
  task automatic wcmd(input logic [6:0] c);
    wr(sce_pkg::OFF_CMD, {25'h0, c});
  endtask
  task automatic move(input logic [3:0] m, input logic [31:0] p,
    input logic d, input logic [31:0] endPos);
    int n;
    wr(sce_pkg::OFF_MOVE, {28'h0, m});
    wr(sce_pkg::OFF_POS, p);
    wcmd(sce_pkg::CMD_INTER);
    tick(2);
    cmp1(act, 1'b1);
    cmp1(dir, d);
    for (n = 0; n < 50 && act === 1'b1; n++) tick(1);
    bail(act === 1'b0);
    rd(sce_pkg::OFF_CURPOS);
    cmp32(q, endPos);
    wcmd(sce_pkg::CMD_IDLE);
  endtask
  initial begin
    int n, cnt;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    wr(sce_pkg::OFF_SPEED, SPD);
    wr(sce_pkg::OFF_STEP0, S0);
    wr(sce_pkg::OFF_STEP1, S1);
    foreach (ROWS[i]) begin
      wr(sce_pkg::OFF_MOVE, {28'h0, ROWS[i].mode});
      wr(sce_pkg::OFF_PMODE, {28'h0, ROWS[i].mode});
      wcmd(ROWS[i].cmd);
      tick(3);
      cmp1(dis, ROWS[i].dis);
      cmp1(act, ROWS[i].act);
      cmp1(dir, ROWS[i].dir);
      cmp32(driveSpeed, !ROWS[i].act ? 32'h0000_0000 :
        ROWS[i].mode[3] ? S0 : SPD);
      wcmd(sce_pkg::CMD_IDLE);
      tick(3);
      cmp1(act, 1'b0);
    end
    // The speed must follow the sensor only after the synchroniser delay.
    wr(sce_pkg::OFF_PMODE, {28'h0, sce_pkg::MV_DUAL_POS});
    wcmd(sce_pkg::CMD_PROFILE);
    @(posedge clk_sys);
    sensorIn <= 1'b1;
    tick(1);
    cmp32(driveSpeed, S0);
    tick(2);
    cmp32(driveSpeed, S1);
    @(posedge clk_sys);
    sensorIn <= 1'b0;
    tick(3);
    cmp32(driveSpeed, S0);
    wcmd(sce_pkg::CMD_IDLE);
    wr(sce_pkg::OFF_MOVE, {28'h0, sce_pkg::MV_MAN_POS});
    wcmd(sce_pkg::CMD_INTER);
    tick(3);
    wr(sce_pkg::OFF_SPEED, 32'h0000_0456);
    tick(2);
    cmp32(driveSpeed, 32'h0000_0456);
    wcmd(sce_pkg::CMD_IDLE);
    wr(sce_pkg::OFF_POS, 32'h0000_0040);
    wcmd(sce_pkg::CMD_RELOAD);
    rd(sce_pkg::OFF_CURPOS);
    cmp32(q, 32'h0000_0040);
    wcmd(sce_pkg::CMD_IDLE);
    move(sce_pkg::MV_ABS, 32'h0000_0045, 1'b0, 32'h0000_0045);
    move(sce_pkg::MV_REL, 32'hFFFF_FFFD, 1'b1, 32'h0000_0042);
    wcmd(sce_pkg::CMD_CLR_PULSE);
    // Look just after the launching edge so the first high cycle counts.
    #1;
    for (n = 0; n < 5 && clr !== 1'b1; n++) tick(1);
    for (cnt = 0; cnt < 99 && clr === 1'b1; cnt++) tick(1);
    cmp32(32'(cnt), 32'(PC));
    wcmd(sce_pkg::CMD_IDLE);
    rd(8'h40);
    cmp32(q, 32'h0000_0000);
    cmp1(hresp, 1'b0);
    cmp1(hreadyout, 1'b1);
    wcmd(sce_pkg::CMD_DIS_ON);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    tick(1);
    cmp1(dis, 1'b0);
    cmp1(clr, 1'b0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(1);
    cmp1(act, 1'b0);
    wcmd(sce_pkg::CMD_DIS_ON);
    tick(1);
    cmp1(dis, 1'b1);
    finish_test();
  end
endmodule

// file: src/sce_pkg.sv
// Package of constants and types for the stepper command executor.
package sce_pkg;
  // AHB-Lite register byte offsets.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_POS = 8'h08;
  localparam logic [7:0] OFF_MOVE = 8'h0C;
  localparam logic [7:0] OFF_STEP0 = 8'h10;
  localparam logic [7:0] OFF_STEP1 = 8'h14;
  localparam logic [7:0] OFF_PMODE = 8'h18;
  localparam logic [7:0] OFF_CURPOS = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_DRVSPD = 8'h24;
  // Command codes.
  localparam logic [6:0] CMD_IDLE = 7'h00;
  localparam logic [6:0] CMD_DIS_ON = 7'h76;
  localparam logic [6:0] CMD_DIS_OFF = 7'h77;
  localparam logic [6:0] CMD_CLR_PULSE = 7'h78;
  localparam logic [6:0] CMD_RELOAD = 7'h79;
  localparam logic [6:0] CMD_INTER = 7'h7A;
  localparam logic [6:0] CMD_PROFILE = 7'h7B;
  // Move and profile modes.
  localparam logic [3:0] MV_ABS = 4'h0;
  localparam logic [3:0] MV_REL = 4'h1;
  localparam logic [3:0] MV_CONT_POS = 4'h2;
  localparam logic [3:0] MV_CONT_NEG = 4'h3;
  localparam logic [3:0] MV_MAN_POS = 4'h4;
  localparam logic [3:0] MV_MAN_NEG = 4'h5;
  localparam logic [3:0] MV_DUAL_POS = 4'h8;
  localparam logic [3:0] MV_DUAL_NEG = 4'h9;
  // Timing.
  localparam int CLK_HZ = 10000000;
  localparam int CLR_PULSE_MS = 50;
  localparam int CLR_PULSE_CYC = CLK_HZ / 1000 * CLR_PULSE_MS;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_DONE} sce_state_t;
endpackage

// file: src/sce_stepper_command_executor.sv
// Command executor of a stepper position module with AHB-Lite registers.
`timescale 1ns/1ps
module sce_stepper_command_executor #(
  parameter int PULSE_CYC = sce_pkg::CLR_PULSE_CYC
) (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write flag.
  input wire logic [2:0] hsize, // AHB transfer size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic referencePointSensorInput, // Sensor pin.
  output logic driveDisableOutput, // Drive-disable pin.
  output logic clearPulseOutput, // Clear pulse pin.
  output logic moveActive, // Motion in progress.
  output logic moveDir, // Direction, high is negative.
  output logic [31:0] driveSpeed // Commanded drive speed.
);
  logic sensorSync;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [6:0] cmd_reg;
  logic [31:0] tgtSpeed_reg;
  logic [31:0] tgtPos_reg;
  logic [3:0] moveSel_reg;
  logic [31:0] step0_reg;
  logic [31:0] step1_reg;
  logic [3:0] profMode_reg;
  logic [31:0] curPos_reg;
  logic [31:0] goalPos_reg;
  logic [31:0] pulseCnt_reg;
  logic [3:0] runMode_reg;
  logic cmdDone_reg;
  sce_pkg::sce_state_t state_reg;
  sce_pkg::sce_state_t state_next;

  // Sensor passes two flip-flops before choosing a speed.
  sce_sync uSync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(referencePointSensorInput),
    .syncOut(sensorSync)
  );

  // Bus decode.
  wire addrPhase = hsel & hready & htrans[1];
  wire wrStart = addrPhase & hwrite;
  wire rdStart = addrPhase & ~hwrite;
  wire [7:0] rdAddr = haddr[7:0];
  wire wrCmd = wrPend_reg && wrAddr_reg == sce_pkg::OFF_CMD;
  wire [6:0] newCmd = hwdata[6:0];

  // Command decode on the written command byte.
  // Only a change of code counts, so software writes idle between repeats.
  wire cmdNew = wrCmd && newCmd != cmd_reg;
  wire isDisOn = cmdNew && newCmd == sce_pkg::CMD_DIS_ON;
  wire isDisOff = cmdNew && newCmd == sce_pkg::CMD_DIS_OFF;
  wire isClr = cmdNew && newCmd == sce_pkg::CMD_CLR_PULSE;
  wire isReload = cmdNew && newCmd == sce_pkg::CMD_RELOAD;
  wire isInter = cmdNew && newCmd == sce_pkg::CMD_INTER;
  wire isProfile = cmdNew && newCmd == sce_pkg::CMD_PROFILE;
  wire cmdIdle = cmd_reg == sce_pkg::CMD_IDLE;

  // Motion selection.
  wire isRel = runMode_reg == sce_pkg::MV_REL;
  wire isStep = runMode_reg == sce_pkg::MV_ABS || isRel;
  wire isCont = runMode_reg == sce_pkg::MV_CONT_POS
    || runMode_reg == sce_pkg::MV_CONT_NEG;
  wire isManual = runMode_reg == sce_pkg::MV_MAN_POS
    || runMode_reg == sce_pkg::MV_MAN_NEG;
  wire isDual = runMode_reg == sce_pkg::MV_DUAL_POS
    || runMode_reg == sce_pkg::MV_DUAL_NEG;
  wire [3:0] startMode = isInter ? moveSel_reg : profMode_reg;
  wire startNeg = startMode == sce_pkg::MV_CONT_NEG
    || startMode == sce_pkg::MV_MAN_NEG
    || startMode == sce_pkg::MV_DUAL_NEG;
  wire startRel = startMode == sce_pkg::MV_REL;
  wire [31:0] relGoal = curPos_reg + tgtPos_reg;
  wire [31:0] startGoal = startRel ? relGoal : tgtPos_reg;
  // Absolute moves take their direction from where the axis stands now.
  wire absNeg = $signed(tgtPos_reg) < $signed(curPos_reg);
  wire relNeg = tgtPos_reg[31];
  wire stepNeg = startRel ? relNeg : absNeg;
  wire startDir = (startMode == sce_pkg::MV_ABS || startRel) ?
    stepNeg : startNeg;
  wire atGoal = curPos_reg == goalPos_reg;
  wire [31:0] dualSpeed = sensorSync ? step1_reg : step0_reg;
  wire [31:0] posStep = moveDir ? 32'hFFFF_FFFF : 32'h0000_0001;
  wire curPosStep = state_reg == sce_pkg::ST_MOVE && isStep && !atGoal;
  wire wrCurPos = wrPend_reg && wrAddr_reg == sce_pkg::OFF_CURPOS;

  // Speed to drive in each running mode.
  logic [31:0] speedNext;
  always_comb begin
    speedNext = sce_pkg::RST_ZERO;
    if (state_reg == sce_pkg::ST_MOVE) begin
      if (isDual) begin
        speedNext = dualSpeed;
      end else begin
        // Manual modes follow the field live as software rewrites it.
        speedNext = tgtSpeed_reg;
      end
    end
  end

  // Motion state machine.
  wire anyStart = isInter || isProfile;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sce_pkg::ST_IDLE: begin
        if (anyStart) begin
          state_next = sce_pkg::ST_MOVE;
        end
      end
      sce_pkg::ST_MOVE: begin
        if (isStep && atGoal) begin
          state_next = sce_pkg::ST_DONE;
        end else if (!isStep && cmdIdle) begin
          state_next = sce_pkg::ST_IDLE;
        end
      end
      sce_pkg::ST_DONE: begin
        // A finished step move waits here so software can see completion.
        if (cmdIdle) begin
          state_next = sce_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = sce_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sce_pkg::ST_IDLE;
      runMode_reg <= 4'h0;
      goalPos_reg <= sce_pkg::RST_ZERO;
      moveDir <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == sce_pkg::ST_IDLE && anyStart) begin
        runMode_reg <= startMode;
        goalPos_reg <= startGoal;
        moveDir <= startDir;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      moveActive <= 1'b0;
      driveSpeed <= sce_pkg::RST_ZERO;
    end else begin
      moveActive <= state_next == sce_pkg::ST_MOVE;
      driveSpeed <= speedNext;
    end
  end

  // Current position: reload wins over stepping and a software write.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      curPos_reg <= sce_pkg::RST_ZERO;
    end else if (isReload) begin
      curPos_reg <= tgtPos_reg;
    end else if (curPosStep) begin
      curPos_reg <= curPos_reg + posStep;
    end else if (wrCurPos) begin
      curPos_reg <= hwdata;
    end
  end

  // Discrete outputs.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      driveDisableOutput <= 1'b0;
    end else if (isDisOn) begin
      driveDisableOutput <= 1'b1;
    end else if (isDisOff) begin
      driveDisableOutput <= 1'b0;
    end
  end

  // A new pulse command while one runs restarts the full width.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt_reg <= sce_pkg::RST_ZERO;
      clearPulseOutput <= 1'b0;
    end else if (isClr) begin
      pulseCnt_reg <= 32'(PULSE_CYC - 1);
      clearPulseOutput <= 1'b1;
    end else if (pulseCnt_reg != sce_pkg::RST_ZERO) begin
      pulseCnt_reg <= pulseCnt_reg - 32'h0000_0001;
    end else begin
      clearPulseOutput <= 1'b0;
    end
  end

  // Bus write path; writes land on the clock edge that ends the data phase.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= wrStart;
      wrAddr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= sce_pkg::CMD_IDLE;
      cmdDone_reg <= 1'b0;
    end else begin
      if (wrCmd) begin
        cmd_reg <= newCmd;
      end
      // Completion wins over a command write landing in the same cycle.
      if (state_reg == sce_pkg::ST_DONE) begin
        cmdDone_reg <= 1'b1;
      end else if (wrCmd) begin
        cmdDone_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgtSpeed_reg <= sce_pkg::RST_ZERO;
      tgtPos_reg <= sce_pkg::RST_ZERO;
      moveSel_reg <= 4'h0;
      step0_reg <= sce_pkg::RST_ZERO;
      step1_reg <= sce_pkg::RST_ZERO;
      profMode_reg <= 4'h0;
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        sce_pkg::OFF_SPEED: tgtSpeed_reg <= hwdata;
        sce_pkg::OFF_POS: tgtPos_reg <= hwdata;
        sce_pkg::OFF_MOVE: moveSel_reg <= hwdata[3:0];
        sce_pkg::OFF_STEP0: step0_reg <= hwdata;
        sce_pkg::OFF_STEP1: step1_reg <= hwdata;
        sce_pkg::OFF_PMODE: profMode_reg <= hwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Read data is registered at the end of the address phase; unmapped reads give zero.
  logic [31:0] rdMux;
  always_comb begin
    case (rdAddr)
      sce_pkg::OFF_CMD: rdMux = {25'h0, cmd_reg};
      sce_pkg::OFF_SPEED: rdMux = tgtSpeed_reg;
      sce_pkg::OFF_POS: rdMux = tgtPos_reg;
      sce_pkg::OFF_MOVE: rdMux = {28'h0, moveSel_reg};
      sce_pkg::OFF_STEP0: rdMux = step0_reg;
      sce_pkg::OFF_STEP1: rdMux = step1_reg;
      sce_pkg::OFF_PMODE: rdMux = {28'h0, profMode_reg};
      sce_pkg::OFF_CURPOS: rdMux = curPos_reg;
      sce_pkg::OFF_STATUS: rdMux = {26'h0, sensorSync, cmdDone_reg,
        clearPulseOutput, driveDisableOutput, moveDir, moveActive};
      sce_pkg::OFF_DRVSPD: rdMux = driveSpeed;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Zero wait states: the slave never stretches a transfer.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdStart) begin
        hrdata <= rdMux;
      end
    end
  end
endmodule

// file: src/sce_sync.sv
// Two-flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module sce_sync (
  input wire logic clk_sys, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic asyncIn, // Level from outside the clock domain.
  output logic syncOut // Synchronised level.
);
  logic meta_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule
